// ==== logic/chan_value_pkg.sv ====
package chan_value_pkg;

   // Access targets on the internal register port
   typedef enum logic [2:0] {
      sel_counter_high   = 3'h0,
      sel_counter_low    = 3'h1,
      sel_timer_sc       = 3'h2,
      sel_channel_sc     = 3'h3,
      sel_channel_high   = 3'h4,
      sel_channel_low    = 3'h5
   } reg_sel_t;

   // Channel operating modes, decoded from the channel status-control write
   typedef enum logic [1:0] {
      mode_input_capture = 2'h0,
      mode_output_compare = 2'h1,
      mode_edge_pwm      = 2'h2,
      mode_edge_pwm_alt  = 2'h3
   } chan_mode_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      reg_sel_t   sel;
      logic [7:0] data;
   } access_t;

   // Read coherency latch: value caught on the first byte read
   typedef struct packed {
      logic        held;
      logic        high_first;
      logic [15:0] value;
   } read_latch_t;

   // Field positions inside the status-control bytes, field codes, reset values and counter top value
   localparam int          CLKS_LSB       = 3;
   localparam int          MODE_LSB       = 4;
   localparam logic [1:0]  CLKS_NONE      = 2'h0;
   localparam logic [1:0]  CLKS_RESET     = 2'h0;
   localparam chan_mode_t  MODE_RESET     = mode_input_capture;
   localparam logic [15:0] COUNTER_RESET  = 16'h0000;
   localparam logic [15:0] CHANNEL_RESET  = 16'h0000;
   localparam logic [15:0] COUNTER_TOP    = 16'hffff;
   localparam logic [7:0]  READ_RESET     = 8'h00;

endpackage

// ==== logic/timer_channel_value_buffering.sv ====
`timescale 1ns/1ns
// Functional notes
// - In debug halt, timer status-control or counter byte writes clear the counter read latch.
// - In debug halt, channel value reads return the live channel register.
// - In debug halt, a channel status-control write clears the channel read latch.
// - In input capture mode, channel value writes are ignored.
// - Output compare with clock selected: load buffer at next counter tick after pair.
// - An update is pending only after both bytes are written.
// - Edge PWM with clock selected: load buffer after pair, at counter wrap.
// - A channel status-control write while an update is pending cancels it.
module timer_channel_value_buffering
   import chan_value_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Status from surrounding logic, same clock
   input  wire logic        debug_halt_mode,
   input  wire logic        prescaler_end,
   input  wire logic [15:0] capture_value,
   input  wire logic        capture_event,
   // CPU register access
   input  wire access_t     access,
   // Results
   output logic [7:0]       read_data,
   output logic [15:0]      channel_value_pair,
   output logic [15:0]      counter_value_pair,
   output logic             update_pending
);

   logic [1:0]  clock_source_select;
   logic [1:0]  next_clock_source_select;
   chan_mode_t  mode;
   chan_mode_t  next_mode;
   logic [15:0] next_counter;
   logic [15:0] next_channel;
   logic [15:0] write_buffer;
   logic [15:0] next_write_buffer;
   logic [1:0]  bytes_written;
   logic [1:0]  next_bytes_written;
   logic        next_pending;
   read_latch_t counter_latch;
   read_latch_t next_counter_latch;
   read_latch_t channel_latch;
   read_latch_t next_channel_latch;
   logic [7:0]  next_read_data;

   logic wr;
   logic rd;
   logic counter_tick;
   logic counter_wrap;
   logic clock_on;

   assign wr           = access.valid && access.write;
   assign rd           = access.valid && !access.write;
   assign clock_on     = clock_source_select != CLKS_NONE;
   // Counter is frozen during debug halt so the image stays stable for the debugger
   assign counter_tick = clock_on && prescaler_end && !debug_halt_mode;
   assign counter_wrap = counter_tick && counter_value_pair == COUNTER_TOP;

   // Control and counter
   always_comb begin
      next_clock_source_select = clock_source_select;
      next_mode                = mode;
      next_counter             = counter_value_pair;
      if (wr && access.sel == sel_timer_sc) begin
         next_clock_source_select = access.data[CLKS_LSB +: 2];
      end
      if (wr && access.sel == sel_channel_sc) begin
         next_mode = chan_mode_t'(access.data[MODE_LSB +: 2]);
      end
      if (wr && (access.sel == sel_counter_high || access.sel == sel_counter_low)) begin
         next_counter = COUNTER_RESET;
      end else if (counter_tick) begin
         next_counter = counter_value_pair + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clock_source_select <= CLKS_RESET;
         mode                <= MODE_RESET;
         counter_value_pair  <= COUNTER_RESET;
      end else begin
         clock_source_select <= next_clock_source_select;
         mode                <= next_mode;
         counter_value_pair  <= next_counter;
      end
   end

   // Channel value write buffering
   always_comb begin
      logic pair_done;
      logic load;
      pair_done          = 1'b0;
      load               = 1'b0;
      next_write_buffer  = write_buffer;
      next_bytes_written = bytes_written;
      next_pending       = update_pending;
      next_channel       = channel_value_pair;
      if (mode == mode_input_capture) begin
         // Writes dropped; only captures move the register
         if (capture_event) begin
            next_channel = capture_value;
         end
         next_bytes_written = 2'h0;
         next_pending       = 1'b0;
      end else if (wr && (access.sel == sel_channel_high || access.sel == sel_channel_low)) begin
         if (access.sel == sel_channel_high) begin
            next_write_buffer[15:8] = access.data;
            next_bytes_written[1]   = 1'b1;
         end else begin
            next_write_buffer[7:0]  = access.data;
            next_bytes_written[0]   = 1'b1;
         end
         pair_done = &next_bytes_written;
         if (pair_done) begin
            next_bytes_written = 2'h0;
            if (!clock_on) begin
               load = 1'b1;
            end else begin
               next_pending = 1'b1;
            end
         end
      end else if (wr && access.sel == sel_channel_sc) begin
         next_pending = 1'b0;
      end else if (update_pending) begin
         if (mode == mode_output_compare && counter_tick) begin
            load = 1'b1;
         end else if (mode != mode_output_compare && counter_wrap) begin
            load = 1'b1;
         end
      end
      if (load) begin
         next_channel = next_write_buffer;
         next_pending = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         write_buffer       <= CHANNEL_RESET;
         bytes_written      <= 2'h0;
         update_pending     <= 1'b0;
         channel_value_pair <= CHANNEL_RESET;
      end else begin
         write_buffer       <= next_write_buffer;
         bytes_written      <= next_bytes_written;
         update_pending     <= next_pending;
         channel_value_pair <= next_channel;
      end
   end

   // Read path with byte-pair coherency latches
   always_comb begin
      next_counter_latch = counter_latch;
      next_channel_latch = channel_latch;
      next_read_data     = read_data;
      if (rd && (access.sel == sel_counter_high || access.sel == sel_counter_low)) begin
         if (!counter_latch.held) begin
            next_counter_latch.held       = 1'b1;
            next_counter_latch.high_first = access.sel == sel_counter_high;
            next_counter_latch.value      = counter_value_pair;
            next_read_data = (access.sel == sel_counter_high) ? counter_value_pair[15:8]
                                                              : counter_value_pair[7:0];
         end else begin
            next_read_data = (access.sel == sel_counter_high) ? counter_latch.value[15:8]
                                                              : counter_latch.value[7:0];
            if (counter_latch.high_first != (access.sel == sel_counter_high)) begin
               next_counter_latch.held = 1'b0;
            end
         end
      end
      if (rd && (access.sel == sel_channel_high || access.sel == sel_channel_low)) begin
         if (debug_halt_mode) begin
            next_read_data = (access.sel == sel_channel_high) ? channel_value_pair[15:8]
                                                              : channel_value_pair[7:0];
         end else if (!channel_latch.held) begin
            next_channel_latch.held       = 1'b1;
            next_channel_latch.high_first = access.sel == sel_channel_high;
            next_channel_latch.value      = channel_value_pair;
            next_read_data = (access.sel == sel_channel_high) ? channel_value_pair[15:8]
                                                              : channel_value_pair[7:0];
         end else begin
            next_read_data = (access.sel == sel_channel_high) ? channel_latch.value[15:8]
                                                              : channel_latch.value[7:0];
            if (channel_latch.high_first != (access.sel == sel_channel_high)) begin
               next_channel_latch.held = 1'b0;
            end
         end
      end
      if (debug_halt_mode && wr && (access.sel == sel_timer_sc
            || access.sel == sel_counter_high || access.sel == sel_counter_low)) begin
         next_counter_latch.held = 1'b0;
      end
      if (debug_halt_mode && wr && access.sel == sel_channel_sc) begin
         next_channel_latch.held = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         counter_latch <= '0;
         channel_latch <= '0;
         read_data     <= READ_RESET;
      end else begin
         counter_latch <= next_counter_latch;
         channel_latch <= next_channel_latch;
         read_data     <= next_read_data;
      end
   end

   // Checks
   sequence s_pair_written;
      wr && access.sel == sel_channel_low && bytes_written == 2'h2;
   endsequence

   a_halt_cnt_clear: assert property (@(posedge clock) disable iff (!rst_b)
      debug_halt_mode && wr && access.sel == sel_timer_sc |=> !counter_latch.held)
      else $error("counter read latch kept after halt write");

   a_halt_live_read: assert property (@(posedge clock) disable iff (!rst_b)
      debug_halt_mode && rd && access.sel == sel_channel_low
      |=> read_data == $past(channel_value_pair[7:0]))
      else $error("halt channel read not live");

   a_halt_chan_clear: assert property (@(posedge clock) disable iff (!rst_b)
      debug_halt_mode && wr && access.sel == sel_channel_sc |=> !channel_latch.held)
      else $error("channel read latch kept after halt write");

   a_capture_no_write: assert property (@(posedge clock) disable iff (!rst_b)
      mode == mode_input_capture && !capture_event |=> $stable(channel_value_pair))
      else $error("channel changed in capture mode without capture");

   a_compare_load: assert property (@(posedge clock) disable iff (!rst_b)
      update_pending && mode == mode_output_compare && counter_tick && !wr
      |=> channel_value_pair == $past(write_buffer) && !update_pending)
      else $error("compare load missed at counter tick");

   a_single_byte: assert property (@(posedge clock) disable iff (!rst_b)
      mode != mode_input_capture && wr && access.sel == sel_channel_high
      && bytes_written == 2'h0 && !update_pending |=> !update_pending)
      else $error("single byte made update pending");

   a_pwm_wait: assert property (@(posedge clock) disable iff (!rst_b)
      update_pending && mode[1] && !counter_wrap && !wr |=> $stable(channel_value_pair))
      else $error("pwm loaded before wrap");

   a_cancel: assert property (@(posedge clock) disable iff (!rst_b)
      mode != mode_input_capture && wr && access.sel == sel_channel_sc
      |=> !update_pending)
      else $error("pending update survived status-control write");

   a_no_clock_load: assert property (@(posedge clock) disable iff (!rst_b)
      mode != mode_input_capture && !clock_on ##0 s_pair_written
      |=> channel_value_pair == {$past(write_buffer[15:8]), $past(access.data)})
      else $error("no-clock pair not loaded at once");

endmodule

// ==== tb/timer_channel_value_buffering_bench.sv ====
`timescale 1ns/1ns
module timer_channel_value_buffering_bench;
   import chan_value_pkg::*;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        debug_halt_mode = 1'b0;
   logic        prescaler_end = 1'b0;
   logic [15:0] capture_value = 16'h0000;
   logic        capture_event = 1'b0;
   access_t     access = '0;
   logic [7:0]  read_data;
   logic [15:0] channel_value_pair;
   logic [15:0] counter_value_pair;
   logic        update_pending;
   int          miscompares = 0;
   int          comparisons = 0;
   int          cnt, chv, clks, mode, pend, wbuf, hw, lw, rd;
   int          c_held, c_hi, c_val, v_held, v_hi, v_val;

   timer_channel_value_buffering timer_channel_value_buffering_inst (
      .clock              (clock),
      .rst_b              (rst_b),
      .debug_halt_mode    (debug_halt_mode),
      .prescaler_end      (prescaler_end),
      .capture_value      (capture_value),
      .capture_event      (capture_event),
      .access             (access),
      .read_data          (read_data),
      .channel_value_pair (channel_value_pair),
      .counter_value_pair (counter_value_pair),
      .update_pending     (update_pending)
   );

   always #25 clock = ~clock;

   task automatic conclude();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input int exp, input string what);
      comparisons++;
      if (got !== 16'(exp)) begin
         miscompares++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, 16'(exp));
      end
   endtask

   // First byte read catches the pair; the other byte frees it
   function automatic int latch_rd(inout int held, inout int hf, inout int val,
                                   input int live, input int hi);
      int r;
      if (held == 0) begin
         held = 1;
         hf = hi;
         val = live;
      end else if (hi != hf) held = 0;
      r = hi ? (val >> 8) & 255 : val & 255;
      return r;
   endfunction

   task automatic model(input access_t a, input int pe, input int ce, input int cv);
      int tick;
      int wr;
      tick = pe && clks != 0 && !debug_halt_mode;
      wr = a.valid && a.write;
      if (a.valid && !a.write) case (a.sel)
         sel_counter_high: rd = latch_rd(c_held, c_hi, c_val, cnt, 1);
         sel_counter_low:  rd = latch_rd(c_held, c_hi, c_val, cnt, 0);
         sel_channel_high: rd = debug_halt_mode ? (chv >> 8) & 255
                                : latch_rd(v_held, v_hi, v_val, chv, 1);
         sel_channel_low:  rd = debug_halt_mode ? chv & 255
                                : latch_rd(v_held, v_hi, v_val, chv, 0);
         default: ;
      endcase
      // Only channel value or channel status-control writes hold off a buffered load
      if (pend && !(wr && a.sel inside {sel_channel_sc, sel_channel_high, sel_channel_low})
          && (mode == 1 ? tick : (tick && cnt == 16'hffff))) begin
         chv = wbuf;
         pend = 0;
      end
      if (tick) cnt = (cnt + 1) & 16'hffff;
      if (ce && mode == 0) chv = cv;
      if (wr) case (a.sel)
         sel_counter_high, sel_counter_low: begin
            cnt = 0;
            if (debug_halt_mode) c_held = 0;
         end
         sel_timer_sc: begin
            clks = (int'(a.data) >> CLKS_LSB) & 3;
            if (debug_halt_mode) c_held = 0;
         end
         sel_channel_sc: begin
            mode = (int'(a.data) >> MODE_LSB) & 3;
            pend = 0;
            if (mode == 0) begin
               hw = 0;
               lw = 0;
            end
            if (debug_halt_mode) v_held = 0;
         end
         default: if (mode != 0) begin
            if (a.sel == sel_channel_high) begin
               wbuf = (wbuf & 255) | (int'(a.data) << 8);
               hw = 1;
            end else begin
               wbuf = (wbuf & 16'hff00) | int'(a.data);
               lw = 1;
            end
            if (hw && lw) begin
               hw = 0;
               lw = 0;
               if (clks == 0) chv = wbuf;
               else pend = 1;
            end
         end
      endcase
   endtask

   // Entered 2 ns after a rising edge and left at the same offset
   task automatic step(input logic v, input logic w, input reg_sel_t s, input logic [7:0] d,
                       input logic pe, input logic ce);
      access = '{valid: v, write: w, sel: s, data: d};
      prescaler_end = pe;
      capture_event = ce;
      capture_value = 16'($urandom);
      model(access, pe, ce, capture_value);
      @(posedge clock);
      #1;
      chk(channel_value_pair, chv, "channel");
      chk(counter_value_pair, cnt, "counter");
      chk({15'h0000, update_pending}, pend, "pending");
      if (v && !w) chk({8'h00, read_data}, rd, "read");
      #1;
   endtask

   task automatic wr(input reg_sel_t s, input logic [7:0] d);
      step(1'b1, 1'b1, s, d, 1'b0, 1'b0);
   endtask

   task automatic rdr(input reg_sel_t s);
      step(1'b1, 1'b0, s, 8'h00, 1'b0, 1'b0);
   endtask

   task automatic idle(input logic pe);
      step(1'b0, 1'b0, sel_counter_high, 8'h00, pe, 1'b0);
   endtask

   task automatic pair();
      wr(sel_channel_low, 8'($urandom));
      wr(sel_channel_high, 8'($urandom));
   endtask

   initial begin
      #5_000_000;
      miscompares++;
      conclude();
   end

   initial begin
      void'($urandom(66));
      {cnt, chv, clks, mode, pend, wbuf, hw, lw, rd} = '0;
      {c_held, c_hi, c_val, v_held, v_hi, v_val} = '0;
      repeat (8) @(posedge clock);
      #2;
      rst_b = 1'b1;
      pair();
      step(1'b0, 1'b0, sel_counter_high, 8'h00, 1'b0, 1'b1);
      wr(sel_channel_sc, 8'h10);
      wr(sel_channel_high, 8'($urandom));
      wr(sel_channel_low, 8'($urandom));
      wr(sel_timer_sc, 8'h08);
      repeat (4) begin
         pair();
         idle(1'b0);
         idle(1'b1);
      end
      pair();
      begin : confirm
         int seen;
         int tries;
         seen = -1;
         tries = 0;
         // Software polls both bytes before touching status-control again
         while (seen != wbuf && tries < 4) begin
            rdr(sel_channel_high);
            seen = int'(read_data) << 8;
            rdr(sel_channel_low);
            seen = seen | int'(read_data);
            if (seen != wbuf) idle(1'b1);
            tries++;
         end
         chk(16'(seen), wbuf, "confirm");
      end
      pair();
      wr(sel_channel_sc, 8'h10);
      idle(1'b1);
      wr(sel_channel_sc, 8'h20);
      pair();
      repeat (65540) idle(1'b1);
      wr(sel_channel_sc, 8'h30);
      pair();
      repeat (3) idle(1'b1);
      rdr(sel_counter_high);
      idle(1'b1);
      debug_halt_mode = 1'b1;
      idle(1'b1);
      wr(sel_timer_sc, 8'h08);
      rdr(sel_counter_low);
      debug_halt_mode = 1'b0;
      wr(sel_timer_sc, 8'h00);
      wr(sel_channel_sc, 8'h10);
      rdr(sel_channel_high);
      pair();
      debug_halt_mode = 1'b1;
      rdr(sel_channel_low);
      wr(sel_channel_sc, 8'h10);
      debug_halt_mode = 1'b0;
      rdr(sel_channel_low);
      conclude();
   end
endmodule
